// >>> core/tlb_defs.svh
// Purpose: offsets, field positions, reset values for the tagged tlb
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: included by bare name
//
// Overview of operation
// - current tag is table root bits 11:0
// - tag enable clear forces tag 000h
// - tag enable only settable in long mode
// - bad tag enable set raises protection fault
// - clearing translation while tagged raises fault
// - fill with current tag; match current tag
// - clearing tag enable flushes every entry
// - 32-bit: 4m by 31:22, else 4k
// - extended: 2m by 31:21, 4k by 31:12
// - 64-bit keys 47:30, 47:21, 47:12
// - store frame, anded write/user, ored noexec
// - store final-level dirty and memory type
// - fetch-only buffer may drop write, dirty
// - fill only if all levels valid, clean
// - set accessed flags first, then fill
// - speculative walks may fill too
// - hits answer from cache, no refresh
// - memory type comes from cached entry
// - large page composed from frame, address
// - entries may vanish at any time
// - both page sizes may coexist
// - shared entries match any context tag
`ifndef TLB_DEFS_SVH
`define TLB_DEFS_SVH
`define ADR_CORE_CTRL 8'h00
`define ADR_FEAT_CTRL 8'h04
`define ADR_ROOT_CTRL 8'h08
`define ADR_EXT_FEAT 8'h0c
`define ADR_STATUS 8'h10
`define BIT_TRANS_ON 31
`define BIT_BIG_PAGE 4
`define BIT_EXT_PHYS 5
`define BIT_SHARED_EN 7
`define BIT_TAG_EN 17
`define BIT_LONG_MODE 10
`define BIT_NOEXEC_EN 11
`define RST_REG 32'h0000_0000
`define NUM_ENTRIES 8
`define NUM_LEVELS 4
`endif

// >>> core/tlb_pkg.sv
// Purpose: shared types for the tagged tlb
// Assumes: nothing
// Notes: constants live in tlb_defs.svh
package tlb_pkg;
  typedef enum logic [1:0] {
    pg_4k = 2'h0,
    pg_2m = 2'h1,
    pg_4m = 2'h2,
    pg_1g = 2'h3
  } pg_size_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_walk = 2'b01,
    st_acc = 2'b11,
    st_fill = 2'b10
  } state_t;
endpackage

// >>> core/tlb_key_match.sv
// Purpose: one entry's page-number and context comparison
// Assumes: page number is linear bits 47:12
// Notes: pure logic
`timescale 1ns/1ns
module tlb_key_match
  import tlb_pkg::*;
(
  input wire logic ent_valid,
  input wire logic [35:0] ent_vpn,
  input wire tlb_pkg::pg_size_t ent_size,
  input wire logic [11:0] ent_tag,
  input wire logic ent_global,
  input wire logic [35:0] q_vpn,
  input wire logic [11:0] cur_tag,
  input wire logic shared_en,
  output logic hit
);
  logic [35:0] mask;
  logic ctx_ok;
  always_comb begin
    case (ent_size)
      pg_2m: mask = {27'h7ffffff, 9'h000};
      pg_4m: mask = {26'h3ffffff, 10'h000};
      pg_1g: mask = {18'h3ffff, 18'h00000};
      default: mask = 36'hf_ffff_ffff;
    endcase
  end
  // global entries ignore the tag while shared_en is set
  assign ctx_ok = (ent_tag == cur_tag) || (ent_global && shared_en);
  assign hit = ent_valid && ctx_ok && (((ent_vpn ^ q_vpn) & mask) == 36'h0_0000_0000);
endmodule

// >>> core/tlb_walk_combine.sv
// Purpose: fold per-level walk flags into one entry's rights
// Assumes: level_used marks the structure entries a walk touched
// Notes: pure logic
`timescale 1ns/1ns
module tlb_walk_combine (
  input wire logic [3:0] lvl_used,
  input wire logic [3:0] lvl_present,
  input wire logic [3:0] lvl_rsvd,
  input wire logic [3:0] lvl_acc,
  input wire logic [3:0] lvl_w,
  input wire logic [3:0] lvl_u,
  input wire logic [3:0] lvl_nx,
  input wire logic noexec_en,
  output logic walk_ok,
  output logic acc_all,
  output logic [3:0] acc_missing,
  output logic w_all,
  output logic u_all,
  output logic nx_any
);
  assign walk_ok = ((lvl_used & ~lvl_present) == 4'h0) && ((lvl_used & lvl_rsvd) == 4'h0);
  assign acc_missing = lvl_used & ~lvl_acc;
  assign acc_all = (acc_missing == 4'h0);
  assign w_all = &(lvl_w | ~lvl_used);
  assign u_all = &(lvl_u | ~lvl_used);
  // noexec only matters once enabled
  assign nx_any = noexec_en && |(lvl_nx & lvl_used);
endmodule

// >>> core/context_tagged_tlb.sv
// Purpose: context-tagged translation buffer with control registers
// Assumes: classic wishbone slave, one lookup in flight
// Notes: round-robin replacement, flip-flop storage
`timescale 1ns/1ns
`include "tlb_defs.svh"
module context_tagged_tlb
  import tlb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic protection_fault,
  input wire logic lk_req,
  input wire logic [47:0] lk_addr,
  output logic lk_busy,
  output logic lk_ack,
  output logic lk_hit,
  output logic lk_ok,
  output logic [39:0] lk_frame,
  output logic lk_w,
  output logic lk_u,
  output logic lk_nx,
  output logic lk_dirty,
  output logic [2:0] lk_mtype,
  output logic walk_req,
  output logic [47:0] walk_addr,
  input wire logic walk_done,
  input wire logic walk_nofill,
  input wire tlb_pkg::pg_size_t walk_size,
  input wire logic [39:0] walk_frame,
  input wire logic [3:0] walk_used,
  input wire logic [3:0] walk_present,
  input wire logic [3:0] walk_rsvd,
  input wire logic [3:0] walk_acc,
  input wire logic [3:0] walk_w,
  input wire logic [3:0] walk_u,
  input wire logic [3:0] walk_nx,
  input wire logic walk_dirty,
  input wire logic [2:0] walk_mtype,
  input wire logic walk_shared,
  output logic acc_set_req,
  output logic [3:0] acc_set_mask,
  input wire logic acc_set_ack
);
  import tlb_pkg::*;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [31:0] core_ctrl_ff;
  logic [31:0] feature_ctrl_ff;
  logic [31:0] table_root_ctrl_ff;
  logic [31:0] ext_feature_enable_reg_ff;
  logic fault_seen_ff;
  logic wb_ack_ff;
  logic [31:0] wb_dat_ff;
  logic fault_ff;
  logic flush;
  logic wr_go;
  logic [31:0] wr_val;
  logic [31:0] wr_old;
  logic feat_bad;
  logic core_bad;
  logic ctx_tag_enable;
  logic long_mode_active;
  logic [11:0] ctx_tag;

  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_ff;
  always_comb begin
    case (wb_adr_i)
      `ADR_CORE_CTRL: wr_old = core_ctrl_ff;
      `ADR_FEAT_CTRL: wr_old = feature_ctrl_ff;
      `ADR_ROOT_CTRL: wr_old = table_root_ctrl_ff;
      `ADR_EXT_FEAT: wr_old = ext_feature_enable_reg_ff;
      default: wr_old = `RST_REG;
    endcase
  end
  assign wr_val = merge_bytes(wr_old, wb_dat_i, wb_sel_i);
  assign ctx_tag_enable = feature_ctrl_ff[`BIT_TAG_EN];
  assign long_mode_active = ext_feature_enable_reg_ff[`BIT_LONG_MODE];
  assign ctx_tag = ctx_tag_enable ? table_root_ctrl_ff[11:0] : 12'h000;
  // enabling tags needs long mode and a zero tag field
  assign feat_bad = wr_go && (wb_adr_i == `ADR_FEAT_CTRL) && !ctx_tag_enable &&
    wr_val[`BIT_TAG_EN] &&
    (!long_mode_active || (table_root_ctrl_ff[11:0] != 12'h000));
  assign core_bad = wr_go && (wb_adr_i == `ADR_CORE_CTRL) && ctx_tag_enable &&
    !wr_val[`BIT_TRANS_ON];
  assign flush = wr_go && (wb_adr_i == `ADR_FEAT_CTRL) && ctx_tag_enable &&
    !wr_val[`BIT_TAG_EN];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_ctrl_ff <= `RST_REG;
    end else if (wr_go && (wb_adr_i == `ADR_CORE_CTRL) && !core_bad) begin
      core_ctrl_ff <= wr_val;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      feature_ctrl_ff <= `RST_REG;
    end else if (wr_go && (wb_adr_i == `ADR_FEAT_CTRL) && !feat_bad) begin
      feature_ctrl_ff <= wr_val;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      table_root_ctrl_ff <= `RST_REG;
    end else if (wr_go && (wb_adr_i == `ADR_ROOT_CTRL)) begin
      table_root_ctrl_ff <= wr_val;
    end
  end

  // long mode is frozen while tagging is on, so tags never leak out of it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_feature_enable_reg_ff <= `RST_REG;
    end else if (wr_go && (wb_adr_i == `ADR_EXT_FEAT)) begin
      ext_feature_enable_reg_ff <= wr_val;
      if (ctx_tag_enable) begin
        ext_feature_enable_reg_ff[`BIT_LONG_MODE] <= 1'b1;
      end
    end
  end

  // sticky fault flag, write one to clear; a new fault wins
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_seen_ff <= 1'b0;
    end else if (feat_bad || core_bad) begin
      fault_seen_ff <= 1'b1;
    end else if (wr_go && (wb_adr_i == `ADR_STATUS) && wb_sel_i[0] && wb_dat_i[0]) begin
      fault_seen_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_ff <= 1'b0;
    end else begin
      fault_ff <= feat_bad || core_bad;
    end
  end

  // ----------------------------------------
  // wishbone answer
  // ----------------------------------------
  state_t state_ff;
  logic [31:0] rd_val;

  always_comb begin
    case (wb_adr_i)
      `ADR_CORE_CTRL: rd_val = core_ctrl_ff;
      `ADR_FEAT_CTRL: rd_val = feature_ctrl_ff;
      `ADR_ROOT_CTRL: rd_val = table_root_ctrl_ff;
      `ADR_EXT_FEAT: rd_val = ext_feature_enable_reg_ff;
      `ADR_STATUS: rd_val = {17'h00000, ctx_tag, state_ff, fault_seen_ff};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 32'h0000_0000;
    end else begin
      wb_ack_ff <= wb_cyc_i && wb_stb_i && !wb_ack_ff;
      wb_dat_ff <= (wb_cyc_i && wb_stb_i && !wb_we_i) ? rd_val : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // entry storage and match
  // ----------------------------------------
  localparam int NE = `NUM_ENTRIES;
  logic [NE-1:0] hit_vec;
  pg_size_t e_size [NE];
  logic [39:0] e_frame [NE];
  logic [NE-1:0] e_w;
  logic [NE-1:0] e_u;
  logic [NE-1:0] e_nx;
  logic [NE-1:0] e_dirty;
  logic [2:0] e_mtype [NE];
  logic [35:0] q_vpn;
  logic [35:0] q_vpn_ff;
  logic [47:0] q_addr_ff;
  logic fill_en;
  logic [2:0] fill_ptr_ff;
  pg_size_t f_size_ff;
  logic [39:0] f_frame_ff;
  logic f_w_ff;
  logic f_u_ff;
  logic f_nx_ff;
  logic f_dirty_ff;
  logic [2:0] f_mtype_ff;
  logic f_global_ff;

  // 32-bit and extended modes key on bits 31:12 only
  assign q_vpn = long_mode_active ? lk_addr[47:12] : {16'h0000, lk_addr[31:12]};

  for (genvar i = 0; i < NE; i++) begin : g_ent
    logic valid_ff;
    logic [35:0] vpn_ff;
    pg_size_t size_ff;
    logic [11:0] tag_ff;
    logic global_ff;
    logic [39:0] frame_ff;
    // one buffer serves every access, so write and dirty stay stored
    logic [6:0] attr_ff;

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        valid_ff <= 1'b0;
      end else if (flush) begin
        valid_ff <= 1'b0;
      end else if (fill_en && (fill_ptr_ff == 3'(i))) begin
        valid_ff <= 1'b1;
      end
    end

    // the victim is replaced whole, so a live entry may drop at any fill
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        vpn_ff <= 36'h0_0000_0000;
        size_ff <= pg_4k;
        tag_ff <= 12'h000;
        global_ff <= 1'b0;
        frame_ff <= 40'h00_0000_0000;
        attr_ff <= 7'h00;
      end else if (fill_en && (fill_ptr_ff == 3'(i))) begin
        vpn_ff <= q_vpn_ff;
        size_ff <= f_size_ff;
        tag_ff <= ctx_tag;
        global_ff <= f_global_ff;
        frame_ff <= f_frame_ff;
        attr_ff <= {f_w_ff, f_u_ff, f_nx_ff, f_dirty_ff, f_mtype_ff};
      end
    end

    tlb_key_match u_match (
      .ent_valid(valid_ff),
      .ent_vpn(vpn_ff),
      .ent_size(size_ff),
      .ent_tag(tag_ff),
      .ent_global(global_ff),
      .q_vpn(q_vpn),
      .cur_tag(ctx_tag),
      .shared_en(feature_ctrl_ff[`BIT_SHARED_EN]),
      .hit(hit_vec[i])
    );

    assign e_size[i] = size_ff;
    assign e_frame[i] = frame_ff;
    assign e_w[i] = attr_ff[6];
    assign e_u[i] = attr_ff[5];
    assign e_nx[i] = attr_ff[4];
    assign e_dirty[i] = attr_ff[3];
    assign e_mtype[i] = attr_ff[2:0];
  end

  // lowest matching entry wins when page sizes overlap
  logic [2:0] hit_idx;
  always_comb begin
    hit_idx = 3'h0;
    for (int k = NE - 1; k >= 0; k--) begin
      if (hit_vec[k]) begin
        hit_idx = k[2:0];
      end
    end
  end

  // large pages take their low frame bits from the linear address
  function automatic logic [39:0] compose(
    input logic [39:0] fr,
    input logic [47:0] la,
    input pg_size_t sz
  );
    logic [39:0] r;
    r = fr;
    case (sz)
      pg_2m: r[8:0] = la[20:12];
      pg_4m: r[9:0] = la[21:12];
      pg_1g: r[17:0] = la[29:12];
      default: r = fr;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // walk flag folding
  // ----------------------------------------
  logic walk_ok;
  logic acc_all;
  logic [3:0] acc_missing;
  logic w_all;
  logic u_all;
  logic nx_any;

  tlb_walk_combine u_comb (
    .lvl_used(walk_used),
    .lvl_present(walk_present),
    .lvl_rsvd(walk_rsvd),
    .lvl_acc(walk_acc),
    .lvl_w(walk_w),
    .lvl_u(walk_u),
    .lvl_nx(walk_nx),
    .noexec_en(ext_feature_enable_reg_ff[`BIT_NOEXEC_EN]),
    .walk_ok(walk_ok),
    .acc_all(acc_all),
    .acc_missing(acc_missing),
    .w_all(w_all),
    .u_all(u_all),
    .nx_any(nx_any)
  );

  // ----------------------------------------
  // lookup sequencer
  // ----------------------------------------
  logic take;
  logic fill_ok;
  assign take = (state_ff == st_idle) && lk_req;
  assign fill_ok = walk_done && !walk_nofill && walk_ok;
  assign fill_en = (state_ff == st_fill);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= st_idle;
    end else begin
      case (state_ff)
        st_idle: if (take && hit_vec == '0) state_ff <= st_walk;
        st_walk: begin
          if (fill_ok && !acc_all) begin
            state_ff <= st_acc;
          end else if (fill_ok) begin
            state_ff <= st_fill;
          end else if (walk_done) begin
            state_ff <= st_idle;
          end
        end
        st_acc: if (acc_set_ack) state_ff <= st_fill;
        st_fill: state_ff <= st_idle;
        default: state_ff <= st_idle;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_vpn_ff <= 36'h0_0000_0000;
      q_addr_ff <= 48'h0000_0000_0000;
    end else if (take) begin
      q_vpn_ff <= q_vpn;
      q_addr_ff <= lk_addr;
    end
  end

  logic walk_req_ff;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      walk_req_ff <= 1'b0;
    end else if (take && hit_vec == '0) begin
      walk_req_ff <= 1'b1;
    end else if (walk_done) begin
      walk_req_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_set_req <= 1'b0;
      acc_set_mask <= 4'h0;
    end else if (state_ff == st_walk && fill_ok && !acc_all) begin
      acc_set_req <= 1'b1;
      acc_set_mask <= acc_missing;
    end else if (acc_set_ack) begin
      acc_set_req <= 1'b0;
      acc_set_mask <= 4'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      f_size_ff <= pg_4k;
      f_frame_ff <= 40'h00_0000_0000;
      f_w_ff <= 1'b0;
      f_u_ff <= 1'b0;
      f_nx_ff <= 1'b0;
      f_dirty_ff <= 1'b0;
      f_mtype_ff <= 3'h0;
      f_global_ff <= 1'b0;
    end else if (state_ff == st_walk && fill_ok) begin
      f_size_ff <= walk_size;
      f_frame_ff <= walk_frame;
      f_w_ff <= w_all;
      f_u_ff <= u_all;
      f_nx_ff <= nx_any;
      f_dirty_ff <= walk_dirty;
      f_mtype_ff <= walk_mtype;
      f_global_ff <= walk_shared;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fill_ptr_ff <= 3'h0;
    end else if (fill_en) begin
      fill_ptr_ff <= fill_ptr_ff + 3'h1;
    end
  end

  // ----------------------------------------
  // lookup answer
  // ----------------------------------------
  logic lk_ack_ff;
  logic lk_hit_ff;
  logic lk_ok_ff;
  logic [39:0] lk_frame_ff;
  logic [5:0] lk_attr_ff;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lk_ack_ff <= 1'b0;
      lk_hit_ff <= 1'b0;
      lk_ok_ff <= 1'b0;
      lk_frame_ff <= 40'h00_0000_0000;
      lk_attr_ff <= 6'h00;
    end else if (take && hit_vec != '0) begin
      lk_ack_ff <= 1'b1;
      lk_hit_ff <= 1'b1;
      lk_ok_ff <= 1'b1;
      lk_frame_ff <= compose(e_frame[hit_idx], lk_addr, e_size[hit_idx]);
      lk_attr_ff <= {e_w[hit_idx], e_u[hit_idx], e_nx[hit_idx], e_dirty[hit_idx],
        e_mtype[hit_idx][1:0]};
    end else if (fill_en) begin
      lk_ack_ff <= 1'b1;
      lk_hit_ff <= 1'b0;
      lk_ok_ff <= 1'b1;
      lk_frame_ff <= compose(f_frame_ff, q_addr_ff, f_size_ff);
      lk_attr_ff <= {f_w_ff, f_u_ff, f_nx_ff, f_dirty_ff, f_mtype_ff[1:0]};
    end else if (state_ff == st_walk && walk_done && !fill_ok) begin
      lk_ack_ff <= 1'b1;
      lk_hit_ff <= 1'b0;
      lk_ok_ff <= 1'b0;
      lk_frame_ff <= 40'h00_0000_0000;
      lk_attr_ff <= 6'h00;
    end else begin
      lk_ack_ff <= 1'b0;
    end
  end

  logic [2:0] lk_mtype_ff;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lk_mtype_ff <= 3'h0;
    end else if (take && hit_vec != '0) begin
      lk_mtype_ff <= e_mtype[hit_idx];
    end else if (fill_en) begin
      lk_mtype_ff <= f_mtype_ff;
    end
  end

  logic busy_ff;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (take && hit_vec == '0) || (state_ff != st_idle && !fill_en &&
        !(state_ff == st_walk && walk_done && !fill_ok));
    end
  end

  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;
  assign protection_fault = fault_ff;
  assign lk_busy = busy_ff;
  assign lk_ack = lk_ack_ff;
  assign lk_hit = lk_hit_ff;
  assign lk_ok = lk_ok_ff;
  assign lk_frame = lk_frame_ff;
  assign lk_w = lk_attr_ff[5];
  assign lk_u = lk_attr_ff[4];
  assign lk_nx = lk_attr_ff[3];
  assign lk_dirty = lk_attr_ff[2];
  assign lk_mtype = lk_mtype_ff;
  assign walk_req = walk_req_ff;
  assign walk_addr = q_addr_ff;
endmodule

// >>> test/context_tagged_tlb_monitor.sv
// Purpose: port-level checks for the tagged tlb
// Assumes: top-level ports only, one clock
// Notes: bound from the bench top file
`timescale 1ns/1ns
module context_tagged_tlb_monitor (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic protection_fault,
  input wire logic lk_req,
  input wire logic lk_busy,
  input wire logic lk_ack,
  input wire logic lk_hit,
  input wire logic lk_ok,
  input wire logic walk_req,
  input wire logic walk_done,
  input wire logic walk_nofill,
  input wire logic acc_set_req,
  input wire logic [3:0] acc_set_mask,
  input wire logic acc_set_ack
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ----------------
  // properties
  // ----------------
  a_fault_on_ctrl: assert property (protection_fault |-> $past(wb_cyc_i && wb_we_i) &&
    ($past(wb_adr_i) == 8'h00 || $past(wb_adr_i) == 8'h04)) else $error("fault without ctrl write");
  a_fault_one_cycle: assert property (protection_fault |=> !protection_fault)
    else $error("fault longer than a pulse");
  a_hit_no_walk: assert property (lk_ack && lk_hit |-> !walk_req && !lk_busy)
    else $error("hit answer while walking");
  a_lookup_taken: assert property (lk_req && !lk_busy |=> lk_ack || walk_req)
    else $error("idle lookup neither answered nor walked");
  a_nofill_answer: assert property (walk_req && walk_done && walk_nofill |=> lk_ack && !lk_ok)
    else $error("declined walk not answered invalid");
  a_walk_held: assert property (walk_req && !walk_done |=> walk_req)
    else $error("walk request dropped early");
  a_busy_walk: assert property (walk_req |-> lk_busy)
    else $error("walking while not busy");
  a_acc_held: assert property (acc_set_req && !acc_set_ack |=> acc_set_req)
    else $error("accessed request dropped early");
  a_acc_mask_set: assert property (acc_set_req |-> acc_set_mask != 4'h0)
    else $error("accessed request with empty mask");
  a_fill_timing: assert property (lk_ack && lk_ok && !lk_hit |->
    $past(walk_done, 2) || $past(acc_set_ack, 2)) else $error("fill answer out of step");
endmodule

// >>> test/walk_partner.sv
// Purpose: page-walk logic model on the walk port
// Assumes: one walk at a time, frames mirror the page number
// Notes: slow mode adds wait cycles before each walk answer
`timescale 1ns/1ns
module walk_partner
  import tlb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic walk_req,
  input wire logic [47:0] walk_addr,
  input wire logic acc_set_req,
  input wire logic cfg_slow,
  input wire logic cfg_nofill,
  input wire logic cfg_rsvd,
  input wire logic cfg_sh,
  input wire logic [3:0] cfg_acc,
  input wire logic [3:0] cfg_w,
  input wire tlb_pkg::pg_size_t cfg_size,
  output logic walk_done,
  output logic walk_nofill,
  output tlb_pkg::pg_size_t walk_size,
  output logic [39:0] walk_frame,
  output logic [3:0] walk_used,
  output logic [3:0] walk_present,
  output logic [3:0] walk_rsvd,
  output logic [3:0] walk_acc,
  output logic [3:0] walk_w,
  output logic [3:0] walk_u,
  output logic [3:0] walk_nx,
  output logic walk_dirty,
  output logic [2:0] walk_mtype,
  output logic walk_shared,
  output logic acc_set_ack
);
  logic pend_ff;
  logic [2:0] cnt_ff;
  logic [1:0] acnt_ff;
  logic [39:0] frame;
  assign frame = {4'h9, walk_addr[47:12]};
  // between answers the frame and nofill lines show junk, not the last value
  assign walk_frame = walk_done ? frame : ~frame;
  assign walk_nofill = walk_done ? cfg_nofill : ~cfg_nofill;
  assign walk_size = cfg_size;
  assign walk_used = 4'hf;
  assign walk_present = 4'hf;
  assign walk_rsvd = {3'h0, cfg_rsvd};
  assign walk_acc = cfg_acc;
  assign walk_w = cfg_w;
  assign walk_u = 4'hf;
  assign walk_nx = 4'h0;
  assign walk_dirty = 1'h1;
  assign walk_mtype = 3'h6;
  assign walk_shared = cfg_sh;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_ff <= 1'h0;
      cnt_ff <= 3'h0;
      walk_done <= 1'h0;
    end else if (walk_req && !pend_ff && !walk_done) begin
      pend_ff <= 1'h1;
      cnt_ff <= cfg_slow ? 3'h6 : 3'h0;
    end else if (pend_ff && cnt_ff != 3'h0) begin
      cnt_ff <= cnt_ff - 3'h1;
    end else begin
      walk_done <= pend_ff;
      pend_ff <= 1'h0;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acnt_ff <= 2'h0;
      acc_set_ack <= 1'h0;
    end else begin
      acnt_ff <= acc_set_req ? acnt_ff + 2'h1 : 2'h0;
      acc_set_ack <= acc_set_req && acnt_ff == 2'h3;
    end
  end
endmodule

// >>> test/context_tagged_tlb_tb.sv
// Purpose: self-checking bench for the tagged tlb
// Assumes: 100 MHz clock, walk partner on the far side
// Notes: frames mirror page numbers, so large pages read identity
`timescale 1ns/1ns
module context_tagged_tlb_tb;
  import tlb_pkg::*;
  logic sys_clk = 1'h0, rst_b = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, protection_fault, pf, lk_req = 1'h0, lk_busy, lk_ack, lk_hit, lk_ok;
  logic lk_w, lk_u, lk_nx, lk_dirty, walk_req, walk_done, walk_nofill, walk_dirty, walk_shared;
  logic acc_set_req, acc_set_ack, cfg_slow = 1'h0, cfg_nofill = 1'h0, cfg_rsvd = 1'h0;
  logic cfg_sh = 1'h0;
  logic [47:0] lk_addr = 48'h0, walk_addr;
  logic [39:0] lk_frame, walk_frame;
  logic [2:0] lk_mtype, walk_mtype;
  logic [3:0] walk_used, walk_present, walk_rsvd, walk_acc, walk_w, walk_u, walk_nx;
  logic [3:0] acc_set_mask, cfg_acc = 4'hf, cfg_w = 4'hf;
  pg_size_t walk_size, cfg_size = pg_4k;
  pg_size_t szs [3] = '{pg_4k, pg_2m, pg_1g};
  logic [47:0] offs [3] = '{48'h800, 48'h1f_f000, 48'h3fff_f000};
  logic [47:0] b;
  int fails = 0, total_checks = 0;
  context_tagged_tlb dut (.*);
  walk_partner partner (.*);
  always #5 sys_clk = ~sys_clk;
  // ----------------
  // shared tasks
  // ----------------
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do @(posedge sys_clk); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    pf = protection_fault;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask
  // single-cycle request: held longer it would be taken again at the answer
  task automatic look(input logic [47:0] a, input logic h, ok, w);
    int n;
    n = 0;
    @(posedge sys_clk);
    lk_req <= 1'h1;
    lk_addr <= a;
    @(posedge sys_clk);
    lk_req <= 1'h0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (lk_ack !== 1'h1 && n < 60);
    if (n == 60) fails++;
    chk(lk_hit, h);
    chk(lk_ok, ok);
    if (ok) begin
      chk(lk_frame, {4'h9, a[47:12]});
      chk(lk_w, w);
      chk({lk_u, lk_nx}, 2'h2);
      chk({lk_dirty, lk_mtype}, 4'he);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------
  // tests
  // ----------------
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      rdc(8'(i * 4), 32'h0);
    end
    wb(1'h1, 8'h04, 32'h2_0000);
    chk(pf, 1'h1);
    rdc(8'h04, 32'h0);
    wb(1'h1, 8'h00, 32'h8000_0000);
    wb(1'h1, 8'h0c, 32'h400);
    wb(1'h1, 8'h08, 32'h5);
    wb(1'h1, 8'h04, 32'h2_0000);
    chk(pf, 1'h1);
    wb(1'h1, 8'h08, 32'h0);
    wb(1'h1, 8'h04, 32'h2_0080);
    chk(pf, 1'h0);
    wb(1'h1, 8'h00, 32'h0);
    chk(pf, 1'h1);
    rdc(8'h00, 32'h8000_0000);
    $display("done: control faults");
    look(48'h1234_5000, 1'h0, 1'h1, 1'h1);
    look(48'h1234_5000, 1'h1, 1'h1, 1'h1);
    wb(1'h1, 8'h08, 32'h123);
    rdc(8'h10, 32'h919);
    cfg_nofill <= 1'h1;
    look(48'h1234_5000, 1'h0, 1'h0, 1'h0);
    cfg_nofill <= 1'h0;
    for (int i = 0; i < 3; i++) begin
      b = 48'h7000_0000_0000 | (48'(i) << 32);
      cfg_size <= szs[i];
      look(b, 1'h0, 1'h1, 1'h1);
      look(b + offs[i], 1'h1, 1'h1, 1'h1);
      cfg_nofill <= 1'h1;
      look(b + 48'h4000_0000, 1'h0, 1'h0, 1'h0);
      cfg_nofill <= 1'h0;
    end
    cfg_size <= pg_4k;
    $display("done: tags and sizes");
    cfg_sh <= 1'h1;
    look(48'h5555_6000, 1'h0, 1'h1, 1'h1);
    cfg_sh <= 1'h0;
    wb(1'h1, 8'h08, 32'h456);
    look(48'h5555_6000, 1'h1, 1'h1, 1'h1);
    cfg_rsvd <= 1'h1;
    look(48'h6666_7000, 1'h0, 1'h0, 1'h1);
    cfg_rsvd <= 1'h0;
    look(48'h6666_7000, 1'h0, 1'h1, 1'h1);
    cfg_acc <= 4'h5;
    cfg_slow <= 1'h1;
    cfg_w <= 4'hb;
    look(48'h7777_8000, 1'h0, 1'h1, 1'h0);
    look(48'h7777_8000, 1'h1, 1'h1, 1'h0);
    $display("done: fills");
    wb(1'h1, 8'h08, 32'h0);
    look(48'h1234_5000, 1'h1, 1'h1, 1'h1);
    wb(1'h1, 8'h04, 32'h0);
    rdc(8'h10, 32'h1);
    cfg_nofill <= 1'h1;
    look(48'h1234_5000, 1'h0, 1'h0, 1'h0);
    $display("done: flush");
    wb(1'h1, 8'h0c, 32'h0);
    cfg_nofill <= 1'h0;
    cfg_size <= pg_4m;
    look(48'h1240_0000, 1'h0, 1'h1, 1'h0);
    look(48'h127f_f000, 1'h1, 1'h1, 1'h0);
    $display("done: 32-bit");
    print_verdict();
  end
  initial begin
    #200000;
    fails++;
    print_verdict();
  end
endmodule
bind context_tagged_tlb context_tagged_tlb_monitor mon (.*);
